// file: rtl/bcv_latch.sv
// Boot configuration vector capture, decode and pin selection
// Function
// - Sample vector from data bus during cold reset
// - Captured settings apply once cold reset completes
// - Bits 2:0 select clock multiplier two/three/four
// - Bit 3 selects little or big endian
// - Bit 5 selects normal or debug start address
// - Bits 7:6 select 8/16/32-bit boot width
// - Bit 8 enables trace and debug tap pins
// - Bit 9 selects 4096 or 64 cycle reset
// - Bit 10 puts DMA channel code on pins
// - Bit 11 holds system clock output constant
// - Bit 12 makes pin 2 boundary-scan reset
// - Bit 13 puts CPU/DMA indicator on pin 4
//
// The plain strobed port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`include "bcv_defs.svh"

module bcv_latch #(
  parameter int LONG_CYC = `BCV_RESET_LONG_CYC,
  parameter int FAST_CYC = `BCV_RESET_FAST_CYC
) (
  // Clock and cold reset
  input  wire logic        clk,
  input  wire logic        reset_output,
  // Strap inputs
  input  wire logic [15:0] memory_data_bus_in,
  // Register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output      logic [31:0] reg_rdata,
  // Decoded settings
  output      logic        reset_output_n,
  output      logic [2:0]  cpu_clock_mult,
  output      logic        big_endian,
  output      logic [31:0] reset_vector,
  output      logic [5:0]  boot_width,
  output      logic        config_error,
  output      logic        system_clock_output,
  // Alternate function sources from the core
  input  wire logic [2:0]  trace_status_pins,
  input  wire logic        trace_clock_pin,
  input  wire logic [3:0]  dma_channel_code,
  input  wire logic        cpu_dma_indicator,
  // Alternate function inputs to the core
  output      logic        debug_tap_reset_pin_n,
  output      logic        bscan_reset_n,
  // General purpose pins
  input  wire logic [31:0] general_purpose_pin_in,
  output      logic [31:0] general_purpose_pin_out,
  output      logic [31:0] general_purpose_pin_oe_n
);

  // Reserved fields must read zero and reserved codes are flagged
  function automatic logic vec_bad(input logic [15:0] v);
    vec_bad = (v[`BCV_F_MULT_HI:`BCV_F_MULT_LO] > `BCV_MULT_CODE_X4)
            || v[`BCV_F_RSVD4]
            || (v[`BCV_F_WIDTH_HI:`BCV_F_WIDTH_LO] > `BCV_WIDTH_CODE_32)
            || (v[`BCV_F_RSVD_HI:`BCV_F_RSVD_LO] != 2'h0);
  endfunction : vec_bad

  // Multiplier factor; reserved codes fall back to two
  function automatic logic [2:0] mult_of(input logic [2:0] code);
    unique case (code)
      `BCV_MULT_CODE_X3: mult_of = `BCV_MULT_X3;
      `BCV_MULT_CODE_X4: mult_of = `BCV_MULT_X4;
      default:           mult_of = `BCV_MULT_X2;
    endcase
  endfunction : mult_of

  // Boot width in bits; reserved code falls back to eight
  function automatic logic [5:0] width_of(input logic [1:0] code);
    unique case (code)
      `BCV_WIDTH_CODE_16: width_of = `BCV_WIDTH_16;
      `BCV_WIDTH_CODE_32: width_of = `BCV_WIDTH_32;
      default:            width_of = `BCV_WIDTH_8;
    endcase
  endfunction : width_of

  // Alternate function values placed on their pins
  function automatic logic [31:0] alt_value(input logic [2:0] pcst, input logic dclk,
                                            input logic [3:0] dma, input logic cpu);
    logic [31:0] v;
    v = 32'h0;
    v[`BCV_PIN_TRACE_LO+:3]  = pcst;
    v[`BCV_PIN_TRACE_CLK]    = dclk;
    v[`BCV_PIN_DMA3]         = dma[3];
    v[`BCV_PIN_DMA2]         = dma[2];
    v[`BCV_PIN_DMA1]         = dma[1];
    v[`BCV_PIN_DMA0]         = dma[0];
    v[`BCV_PIN_CPU_IND]      = cpu;
    alt_value = v;
  endfunction : alt_value

  bcv_pkg::bcv_state_t state_reg;
  bcv_pkg::bcv_state_t state_next;
  logic [1:0]          sync_cnt_reg;
  logic [15:0]         memory_data_bus_s1_reg;
  logic [15:0]         memory_data_bus_s2_reg;
  logic [31:0]         pin_s1_reg;
  logic [31:0]         pin_s2_reg;
  logic [15:0]         vector_reg;
  logic [31:0]         gpio_data_reg;
  logic [31:0]         gpio_dir_reg;
  logic                sysclk_reg;

  bcv_timer_if tif ();

  bcv_reset_timer #(
    .LONG_CYC (LONG_CYC),
    .FAST_CYC (FAST_CYC)
  ) u_timer (
    .clk  (clk),
    .reset_output (reset_output),
    .tif  (tif)
  );

  // Sequencer decode
  logic run_next;
  assign tif.start = (state_reg == bcv_pkg::ST_CAPTURE);
  // Timer loads at the capture edge, before the latch holds the new vector
  assign tif.fast  = memory_data_bus_s2_reg[`BCV_F_FAST_RESET];
  assign run_next  = (state_next == bcv_pkg::ST_RUN);

  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      bcv_pkg::ST_SYNC:    if (sync_cnt_reg == `BCV_SYNC_LAST) state_next = bcv_pkg::ST_CAPTURE;
      bcv_pkg::ST_CAPTURE: state_next = bcv_pkg::ST_HOLD;
      bcv_pkg::ST_HOLD:    if (tif.done) state_next = bcv_pkg::ST_RUN;
      bcv_pkg::ST_RUN:     state_next = bcv_pkg::ST_RUN;
    endcase
  end

  // Sequencer state; only a new cold reset returns to sync
  always_ff @(posedge clk or negedge reset_output)
  begin
    if (!reset_output)
    begin
      state_reg    <= bcv_pkg::ST_SYNC;
      sync_cnt_reg <= 2'h0;
    end
    else
    begin
      state_reg    <= state_next;
      sync_cnt_reg <= sync_cnt_reg + 2'h1;
    end
  end

  // Pins are asynchronous to clk, so two flops before any use
  always_ff @(posedge clk or negedge reset_output)
  begin
    if (!reset_output)
    begin
      memory_data_bus_s1_reg <= 16'h0;
      memory_data_bus_s2_reg <= 16'h0;
      pin_s1_reg   <= 32'h0;
      pin_s2_reg   <= 32'h0;
    end
    else
    begin
      memory_data_bus_s1_reg <= memory_data_bus_in;
      memory_data_bus_s2_reg <= memory_data_bus_s1_reg;
      pin_s1_reg   <= general_purpose_pin_in;
      pin_s2_reg   <= pin_s1_reg;
    end
  end

  // Vector latch; captured once per cold reset, ignored afterwards
  always_ff @(posedge clk or negedge reset_output)
  begin
    if (!reset_output)
      vector_reg <= 16'h0;
    else if (state_reg == bcv_pkg::ST_CAPTURE)
      vector_reg <= memory_data_bus_s2_reg;
  end

  // Decoded enables
  logic        ice_en;
  logic        dma_en;
  logic        bscan_en;
  logic        cpu_en;
  logic [31:0] drive_mask;
  logic [31:0] in_mask;
  logic [31:0] alt_val;
  logic [31:0] pin_out_next;
  logic [31:0] pin_oe_n_next;
  assign ice_en   = vector_reg[`BCV_F_ICE_EN];
  assign dma_en   = vector_reg[`BCV_F_DMA_EN];
  assign bscan_en = vector_reg[`BCV_F_BSCAN_EN];
  assign cpu_en   = vector_reg[`BCV_F_CPU_IND_EN];

  // Alternate functions override the general purpose setting per pin
  assign drive_mask = ({32{ice_en}} & `BCV_MASK_ICE_OUT)
                    | ({32{dma_en}} & `BCV_MASK_DMA)
                    | ({32{cpu_en}} & `BCV_MASK_CPU);
  assign in_mask    = ({32{ice_en}} & `BCV_MASK_ICE_IN)
                    | ({32{bscan_en}} & `BCV_MASK_BSCAN);
  assign alt_val    = alt_value(trace_status_pins, trace_clock_pin,
                                dma_channel_code, cpu_dma_indicator);
  assign pin_out_next  = run_next ? ((gpio_data_reg & ~drive_mask) | (alt_val & drive_mask))
                                  : 32'h0;
  // Nothing is driven until the straps have been released by reset
  assign pin_oe_n_next = run_next ? ~((gpio_dir_reg & ~in_mask & ~drive_mask) | drive_mask)
                                  : 32'hffff_ffff;

  // Pin and alternate input registers
  always_ff @(posedge clk or negedge reset_output)
  begin
    if (!reset_output)
    begin
      general_purpose_pin_out  <= 32'h0;
      general_purpose_pin_oe_n <= 32'hffff_ffff;
      debug_tap_reset_pin_n    <= 1'b1;
      bscan_reset_n            <= 1'b1;
    end
    else
    begin
      general_purpose_pin_out  <= pin_out_next;
      general_purpose_pin_oe_n <= pin_oe_n_next;
      debug_tap_reset_pin_n    <= !(run_next && ice_en) || pin_s2_reg[`BCV_PIN_TAP_RST];
      bscan_reset_n            <= !(run_next && bscan_en) || pin_s2_reg[`BCV_PIN_BSCAN_RST];
    end
  end

  // Settings outputs take the vector only when reset completes
  always_ff @(posedge clk or negedge reset_output)
  begin
    if (!reset_output)
    begin
      reset_output_n <= 1'b0;
      cpu_clock_mult <= `BCV_MULT_X2;
      big_endian     <= 1'b0;
      reset_vector   <= `BCV_VEC_NORMAL;
      boot_width     <= `BCV_WIDTH_8;
      config_error   <= 1'b0;
    end
    else
    begin
      reset_output_n <= run_next;
      cpu_clock_mult <= run_next ? mult_of(vector_reg[`BCV_F_MULT_HI:`BCV_F_MULT_LO])
                                 : `BCV_MULT_X2;
      big_endian     <= run_next && vector_reg[`BCV_F_ENDIAN];
      reset_vector   <= (run_next && vector_reg[`BCV_F_DEBUG_BOOT]) ? `BCV_VEC_DEBUG
                                                                   : `BCV_VEC_NORMAL;
      boot_width     <= run_next ? width_of(vector_reg[`BCV_F_WIDTH_HI:`BCV_F_WIDTH_LO])
                                 : `BCV_WIDTH_8;
      config_error   <= run_next && vec_bad(vector_reg);
    end
  end

  // System clock output; holding it lowers emissions on boards using clk
  always_ff @(posedge clk or negedge reset_output)
  begin
    if (!reset_output)
      sysclk_reg <= 1'b0;
    else if (!(run_next && vector_reg[`BCV_F_HOLD_SYSCLK]))
      sysclk_reg <= ~sysclk_reg;
  end
  assign system_clock_output = sysclk_reg;

  // Register decode
  logic        hit_data;
  logic        hit_dir;
  logic [31:0] status_val;
  logic [31:0] rd_mux;
  assign hit_data   = (reg_addr == `BCV_REG_GPIO_DATA);
  assign hit_dir    = (reg_addr == `BCV_REG_GPIO_DIR);
  assign status_val = {29'h0, config_error, big_endian, reset_output_n};
  assign rd_mux     = (reg_addr == `BCV_REG_VECTOR)    ? {16'h0, vector_reg} :
                      (reg_addr == `BCV_REG_STATUS)    ? status_val :
                      hit_data                         ? gpio_data_reg :
                      hit_dir                          ? gpio_dir_reg :
                      (reg_addr == `BCV_REG_PIN_IN)    ? pin_s2_reg : 32'h0;

  // Writable registers and one-cycle read data
  always_ff @(posedge clk or negedge reset_output)
  begin
    if (!reset_output)
    begin
      gpio_data_reg <= `BCV_RST_GPIO_DATA;
      gpio_dir_reg  <= `BCV_RST_GPIO_DIR;
      reg_rdata     <= 32'h0;
    end
    else
    begin
      if (reg_wr && hit_data)
        gpio_data_reg <= reg_wdata;
      if (reg_wr && hit_dir)
        gpio_dir_reg <= reg_wdata;
      reg_rdata <= reg_rd ? rd_mux : 32'h0;
    end
  end

  // Checking helpers
  logic [15:0] hold_cnt_reg;
  logic        run_q;
  assign run_q = (state_reg == bcv_pkg::ST_RUN);
  always_ff @(posedge clk or negedge reset_output)
  begin
    if (!reset_output)
      hold_cnt_reg <= 16'h0;
    else if (state_reg == bcv_pkg::ST_HOLD)
      hold_cnt_reg <= hold_cnt_reg + 16'h1;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_output);

  capture_sample_a: assert property (
    (state_reg == bcv_pkg::ST_CAPTURE) |=> (vector_reg == $past(memory_data_bus_s2_reg)))
    else $error("vector not taken from strap bus");
  vector_hold_a: assert property (
    run_q && $past(run_q) |-> $stable(vector_reg))
    else $error("vector changed after capture");
  apply_at_done_a: assert property (
    $rose(reset_output_n) |-> $past(state_reg == bcv_pkg::ST_HOLD) && run_q)
    else $error("settings applied outside reset completion");
  clock_mult_a: assert property (
    run_q |-> cpu_clock_mult == mult_of(vector_reg[`BCV_F_MULT_HI:`BCV_F_MULT_LO]))
    else $error("wrong clock multiplier");
  endian_sel_a: assert property (
    run_q |-> big_endian == vector_reg[`BCV_F_ENDIAN])
    else $error("wrong endianness");
  boot_addr_a: assert property (
    run_q |-> reset_vector == (vector_reg[`BCV_F_DEBUG_BOOT] ? `BCV_VEC_DEBUG : `BCV_VEC_NORMAL))
    else $error("wrong first fetch address");
  boot_width_a: assert property (
    run_q |-> boot_width == width_of(vector_reg[`BCV_F_WIDTH_HI:`BCV_F_WIDTH_LO]))
    else $error("wrong boot width");
  reset_len_a: assert property (
    $rose(reset_output_n) |-> hold_cnt_reg ==
      (vector_reg[`BCV_F_FAST_RESET] ? 16'(FAST_CYC) : 16'(LONG_CYC)))
    else $error("wrong reset output length");
  trace_pins_a: assert property (
    run_q && $past(run_q) && ice_en |-> !general_purpose_pin_oe_n[`BCV_PIN_TRACE_LO]
      && general_purpose_pin_oe_n[`BCV_PIN_TAP_RST]
      && general_purpose_pin_out[`BCV_PIN_TRACE_CLK] == $past(trace_clock_pin))
    else $error("trace pins not selected");
  dma_pins_a: assert property (
    run_q && $past(run_q) && dma_en |-> !general_purpose_pin_oe_n[`BCV_PIN_DMA0]
      && general_purpose_pin_out[`BCV_PIN_DMA3] == $past(dma_channel_code[3]))
    else $error("dma code pins not selected");
  sysclk_hold_a: assert property (
    run_q && vector_reg[`BCV_F_HOLD_SYSCLK] |=> $stable(system_clock_output))
    else $error("system clock output toggled while held");
  bscan_pin_a: assert property (
    run_q && $past(run_q) && bscan_en |-> general_purpose_pin_oe_n[`BCV_PIN_BSCAN_RST])
    else $error("boundary-scan reset pin driven");
  cpu_pin_a: assert property (
    run_q && $past(run_q) && cpu_en |->
      general_purpose_pin_out[`BCV_PIN_CPU_IND] == $past(cpu_dma_indicator))
    else $error("cpu indicator not on pin");

  fast_reset_c: cover property ($rose(reset_output_n) && vector_reg[`BCV_F_FAST_RESET]);
  debug_boot_c: cover property (run_q && vector_reg[`BCV_F_DEBUG_BOOT]);
  all_alt_c:    cover property (run_q && ice_en && dma_en && bscan_en && cpu_en);
  cfg_error_c:  cover property ($rose(config_error));

endmodule : bcv_latch

// file: shared/bcv_defs.svh
// Constants for the boot configuration vector latch
`ifndef BCV_DEFS_SVH
`define BCV_DEFS_SVH

// Vector field positions
`define BCV_F_MULT_LO      0
`define BCV_F_MULT_HI      2
`define BCV_F_ENDIAN       3
`define BCV_F_RSVD4        4
`define BCV_F_DEBUG_BOOT   5
`define BCV_F_WIDTH_LO     6
`define BCV_F_WIDTH_HI     7
`define BCV_F_ICE_EN       8
`define BCV_F_FAST_RESET   9
`define BCV_F_DMA_EN       10
`define BCV_F_HOLD_SYSCLK  11
`define BCV_F_BSCAN_EN     12
`define BCV_F_CPU_IND_EN   13
`define BCV_F_RSVD_LO      14
`define BCV_F_RSVD_HI      15

// Clock multiplier codes and factors
`define BCV_MULT_CODE_X2   3'h0
`define BCV_MULT_CODE_X3   3'h1
`define BCV_MULT_CODE_X4   3'h2
`define BCV_MULT_X2        3'h2
`define BCV_MULT_X3        3'h3
`define BCV_MULT_X4        3'h4

// Boot device width codes and bit counts
`define BCV_WIDTH_CODE_8   2'h0
`define BCV_WIDTH_CODE_16  2'h1
`define BCV_WIDTH_CODE_32  2'h2
`define BCV_WIDTH_8        6'h08
`define BCV_WIDTH_16       6'h10
`define BCV_WIDTH_32       6'h20

// First fetch addresses
`define BCV_VEC_NORMAL     32'hbfc0_0000
`define BCV_VEC_DEBUG      32'hff20_0200

// Reset output durations in clock cycles
`define BCV_RESET_LONG_CYC 4096
`define BCV_RESET_FAST_CYC 64

// Strap synchroniser settle count
`define BCV_SYNC_LAST      2'h1

// Pin positions of alternate functions
`define BCV_PIN_TAP_RST    31
`define BCV_PIN_TRACE_LO   10
`define BCV_PIN_TRACE_CLK  13
`define BCV_PIN_DMA3       8
`define BCV_PIN_DMA2       9
`define BCV_PIN_DMA1       25
`define BCV_PIN_DMA0       23
`define BCV_PIN_BSCAN_RST  2
`define BCV_PIN_CPU_IND    4

// Pin masks of alternate functions
`define BCV_MASK_ICE_OUT   32'h0000_3c00
`define BCV_MASK_ICE_IN    32'h8000_0000
`define BCV_MASK_DMA       32'h0280_0300
`define BCV_MASK_BSCAN     32'h0000_0004
`define BCV_MASK_CPU       32'h0000_0010

// Register offsets (byte addresses)
`define BCV_REG_VECTOR     8'h00
`define BCV_REG_STATUS     8'h04
`define BCV_REG_GPIO_DATA  8'h08
`define BCV_REG_GPIO_DIR   8'h0c
`define BCV_REG_PIN_IN     8'h10

// Status register bit positions
`define BCV_ST_DONE        0
`define BCV_ST_BIG_ENDIAN  1
`define BCV_ST_CFG_ERROR   2

// Register reset values
`define BCV_RST_GPIO_DATA  32'h0000_0000
`define BCV_RST_GPIO_DIR   32'h0000_0000

`endif

// file: shared/bcv_pkg.sv
// Types for the boot configuration vector latch
package bcv_pkg;

  // Cold reset sequence
  typedef enum logic [1:0] {
    ST_SYNC,
    ST_CAPTURE,
    ST_HOLD,
    ST_RUN
  } bcv_state_t;

endpackage : bcv_pkg

// file: shared/bcv_timer_if.sv
// Handshake between sequencer and reset-length timer
`timescale 1ns/1ps

interface bcv_timer_if;
  logic start;
  logic fast;
  logic done;

  modport ctrl  (output start, output fast, input done);
  modport timer (input start, input fast, output done);
endinterface : bcv_timer_if

// file: rtl/bcv_reset_timer.sv
// Counts the reset output duration, long or fast
`timescale 1ns/1ps
`include "bcv_defs.svh"

module bcv_reset_timer #(
  parameter int CNT_W    = 13,
  parameter int LONG_CYC = `BCV_RESET_LONG_CYC,
  parameter int FAST_CYC = `BCV_RESET_FAST_CYC
) (
  // Clock and reset
  input wire logic     clk,
  input wire logic     reset_output,
  // Sequencer side
  bcv_timer_if.timer   tif
);

  logic [CNT_W-1:0] cnt_reg;
  logic             busy_reg;
  logic [CNT_W-1:0] load_val;

  // Load one less so that done ends exactly N cycles after start
  assign load_val = tif.fast ? CNT_W'(FAST_CYC - 1) : CNT_W'(LONG_CYC - 1);
  assign tif.done = busy_reg && (cnt_reg == '0);

  // Down counter
  always_ff @(posedge clk or negedge reset_output)
  begin
    if (!reset_output)
    begin
      cnt_reg  <= '0;
      busy_reg <= 1'b0;
    end
    else if (tif.start)
    begin
      cnt_reg  <= load_val;
      busy_reg <= 1'b1;
    end
    else if (busy_reg)
    begin
      cnt_reg  <= cnt_reg - CNT_W'(1);
      busy_reg <= (cnt_reg != '0);
    end
  end

endmodule : bcv_reset_timer

// file: test/bcv_strap_model.sv
// Board strap logic that drives the memory data bus around cold reset
`timescale 1ns/1ps

module bcv_strap_model (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset_output,
  input  wire logic        reset_output_n,
  // Vector to present and permission to break the reserved bits
  input  wire logic [15:0] strap,
  input  wire logic        allow_rsvd,
  // Bus towards the device
  output      logic [15:0] memory_data_bus_in
);
  // Straps held until reset_output_n rises at reset completion, then ordinary bus traffic follows
  always @(posedge clk or negedge reset_output)
  begin
    if (!reset_output || !reset_output_n)
      memory_data_bus_in <= allow_rsvd ? strap : (strap & 16'h3fef);
    else
      memory_data_bus_in <= {memory_data_bus_in[14:0], ~memory_data_bus_in[15]};
  end
endmodule : bcv_strap_model

// file: test/boot_config_vector_latch_test.sv
// Self-checking bench for the boot configuration vector latch
`timescale 1ns/1ps
`include "bcv_defs.svh"

module boot_config_vector_latch_test;
  // Short reset counts keep the run brief
  localparam int LONG_N = 16;
  localparam int FAST_N = 8;

  logic        clk;
  logic        reset_output;
  logic [15:0] strap;
  logic        allow_rsvd;
  logic [15:0] memory_data_bus_in;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [31:0] reg_rdata;
  logic        reset_output_n;
  logic [2:0]  cpu_clock_mult;
  logic        big_endian;
  logic [31:0] reset_vector;
  logic [5:0]  boot_width;
  logic        config_error;
  logic        system_clock_output;
  logic [2:0]  trace_status_pins;
  logic        trace_clock_pin;
  logic [3:0]  dma_channel_code;
  logic        cpu_dma_indicator;
  logic        debug_tap_reset_pin_n;
  logic        bscan_reset_n;
  logic [31:0] general_purpose_pin_in;
  logic [31:0] general_purpose_pin_out;
  logic [31:0] general_purpose_pin_oe_n;
  int          failures;
  int          compares;

  bcv_strap_model u_straps (
    .clk(clk), .reset_output(reset_output), .reset_output_n(reset_output_n), .strap(strap),
    .allow_rsvd(allow_rsvd), .memory_data_bus_in(memory_data_bus_in)
  );

  bcv_latch #(.LONG_CYC(LONG_N), .FAST_CYC(FAST_N)) u_dut (
    .clk(clk), .reset_output(reset_output), .memory_data_bus_in(memory_data_bus_in),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .reset_output_n(reset_output_n),
    .cpu_clock_mult(cpu_clock_mult), .big_endian(big_endian),
    .reset_vector(reset_vector), .boot_width(boot_width), .config_error(config_error),
    .system_clock_output(system_clock_output), .trace_status_pins(trace_status_pins),
    .trace_clock_pin(trace_clock_pin), .dma_channel_code(dma_channel_code),
    .cpu_dma_indicator(cpu_dma_indicator), .debug_tap_reset_pin_n(debug_tap_reset_pin_n),
    .bscan_reset_n(bscan_reset_n), .general_purpose_pin_in(general_purpose_pin_in),
    .general_purpose_pin_out(general_purpose_pin_out),
    .general_purpose_pin_oe_n(general_purpose_pin_oe_n)
  );

  // Free-running 100 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      failures++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic conclude();
    $display("compares=%0d failures=%0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : conclude

  // Single-cycle strobes, changed just after the edge
  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask : reg_write

  task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : reg_read

  // One cold reset with vector v, then every decoded effect compared
  task automatic run_test(input logic [15:0] v);
    int          cyc;
    int          m;
    int          w;
    logic [31:0] rd;
    logic [31:0] d;
    logic [31:0] eo;
    logic [31:0] eoe;
    logic [31:0] imask;
    logic        err;
    logic        s0;
    @(posedge clk);
    strap <= v;
    reset_output  <= 1'b0;
    repeat (2) @(posedge clk);
    reset_output <= 1'b1;
    cyc = 0;
    do
    begin
      @(posedge clk);
      #1;
      cyc++;
      if (cyc == 1)
      begin
        check(reset_output_n, 1'b0);
        check(general_purpose_pin_oe_n, 32'hffff_ffff);
        check(reset_vector, `BCV_VEC_NORMAL);
      end
    end while (reset_output_n !== 1'b1 && cyc < 5000);
    check(cyc, (v[9] ? FAST_N : LONG_N) + 3);
    // Reference decode of the vector
    m   = v[2:0];
    w   = v[7:6];
    err = v[4] | v[15] | v[14] | (m > 2) | (w == 3);
    check(cpu_clock_mult, (m < 3) ? m + 2 : 2);
    check(big_endian, v[3]);
    check(reset_vector, v[5] ? 32'hff20_0200 : 32'hbfc0_0000);
    check(boot_width, (w == 1) ? 16 : (w == 2) ? 32 : 8);
    check(config_error, err);
    // Bus keeps moving; the latched vector must not
    repeat (10) @(posedge clk);
    reg_read(8'h00, rd);
    check(rd, {16'h0000, v});
    reg_read(8'h04, rd);
    check(rd, {29'h0, err, v[3], 1'b1});
    reg_read(8'h3c, rd);
    check(rd, 32'h0000_0000);
    // Pins: every output driven from random core and register values
    d = $urandom;
    @(posedge clk);
    trace_status_pins      <= 3'($urandom);
    trace_clock_pin        <= 1'($urandom);
    dma_channel_code       <= 4'($urandom);
    cpu_dma_indicator      <= 1'($urandom);
    general_purpose_pin_in <= $urandom;
    reg_write(8'h0c, 32'hffff_ffff);
    reg_write(8'h08, d);
    repeat (6) @(posedge clk);
    #1;
    eo    = d;
    eoe   = 32'h0000_0000;
    imask = 32'h0000_0000;
    if (v[8])
    begin
      eo[12:10] = trace_status_pins;
      eo[13]    = trace_clock_pin;
      eoe[31]   = 1'b1;
      imask[31] = 1'b1;
    end
    if (v[10])
      {eo[8], eo[9], eo[25], eo[23]} = dma_channel_code;
    if (v[12])
    begin
      eoe[2]   = 1'b1;
      imask[2] = 1'b1;
    end
    if (v[13])
      eo[4] = cpu_dma_indicator;
    check(general_purpose_pin_out & ~imask, eo & ~imask);
    check(general_purpose_pin_oe_n, eoe);
    check(debug_tap_reset_pin_n, v[8] ? general_purpose_pin_in[31] : 1'b1);
    check(bscan_reset_n, v[12] ? general_purpose_pin_in[2] : 1'b1);
    reg_read(8'h08, rd);
    check(rd, d);
    reg_read(8'h10, rd);
    check(rd, general_purpose_pin_in);
    // All pins inputs by register: only alternate outputs still drive
    reg_write(8'h0c, 32'h0000_0000);
    repeat (2) @(posedge clk);
    #1;
    eoe = 32'hffff_ffff;
    if (v[8])
      eoe[13:10] = 4'h0;
    if (v[10])
      {eoe[8], eoe[9], eoe[25], eoe[23]} = 4'h0;
    if (v[13])
      eoe[4] = 1'b0;
    check(general_purpose_pin_oe_n, eoe);
    // A toggling clock output differs on consecutive cycles
    s0 = system_clock_output;
    @(posedge clk);
    #1;
    check(s0 === system_clock_output, v[11]);
    $display("test vector %h finished", v);
  endtask : run_test

  // Watchdog well beyond the expected run length
  initial
  begin
    #200000;
    failures++;
    conclude();
  end

  initial
  begin
    logic [15:0] v;
    failures               = 0;
    compares               = 0;
    reset_output                   = 1'b0;
    strap                  = 16'h0000;
    allow_rsvd             = 1'b0;
    reg_addr               = 8'h00;
    reg_wdata              = 32'h0000_0000;
    reg_wr                 = 1'b0;
    reg_rd                 = 1'b0;
    trace_status_pins      = 3'h0;
    trace_clock_pin        = 1'b0;
    dma_channel_code       = 4'h0;
    cpu_dma_indicator      = 1'b0;
    general_purpose_pin_in = 32'h0000_0000;
    void'($urandom(32'hd24f6f27));
    repeat (2) @(posedge clk);
    // Every legal code, each option on and off, both reset lengths
    for (int k = 0; k < 6; k++)
    begin
      v        = 16'($urandom);
      v[2:0]   = 3'(k % 3);
      v[7:6]   = 2'((k + 1) % 3);
      v[4]     = 1'b0;
      v[15:14] = 2'h0;
      v[3]     = ~k[0];
      v[5]     = k[0];
      v[8]     = k[0];
      v[13:10] = {4{k[0]}};
      v[9]     = k[1];
      run_test(v);
    end
    // Reserved codes and bits presented on purpose
    allow_rsvd = 1'b1;
    run_test(16'hc0d5);
    run_test(16'h0313);
    allow_rsvd = 1'b0;
    conclude();
  end
endmodule : boot_config_vector_latch_test
